// ---- common/sq_pkg.sv ----
// Shared constants, encodings and carrier types of the store queue block.
package sq_pkg;
  localparam int              QUEUES        = 2;
  localparam int              SLOTS         = 8;
  localparam int              LW_BITS       = 32;
  localparam int              IDX_BITS      = 4;
  localparam int              BURST_BITS    = 5;
  localparam int              SQ_TAG_LSB    = 26;
  localparam int              RB_TAG_LSB    = 6;
  localparam int              QSEL_BIT      = 5;
  localparam int              SLOT_LSB      = 2;
  localparam int              SLOT_MSB      = 4;
  localparam logic [5:0]      SQ_AREA_TAG   = 6'h38;
  localparam logic [25:0]     RB_AREA_TAG   = 26'h3fc0040;

  localparam logic [7:0]      OFF_MMU_CTRL  = 8'h00;
  localparam logic [7:0]      OFF_QAC_A     = 8'h04;
  localparam logic [7:0]      OFF_QAC_B     = 8'h08;
  localparam logic [7:0]      OFF_STATUS    = 8'h0c;
  localparam int              AT_BIT        = 0;
  localparam int              PRIVONLY_BIT  = 1;
  localparam int              QAC_LSB       = 2;
  localparam int              QAC_MSB       = 4;
  localparam int              ST_BUSY_BIT   = 0;
  localparam int              ST_QUEUE_BIT  = 1;
  localparam int              ST_EXC_LSB    = 4;
  localparam int              ST_EXC_MSB    = 6;
  localparam logic            RST_AT        = 1'b0;
  localparam logic            RST_PRIVONLY  = 1'b0;
  localparam logic [2:0]      RST_QAC       = 3'h0;

  localparam int              PROT_WRITE_BIT = 0;
  localparam int              PROT_USER_BIT  = 1;
  localparam logic [1:0]      PG_1K         = 2'h0;
  localparam logic [1:0]      PG_4K         = 2'h1;
  localparam logic [1:0]      PG_64K        = 2'h2;
  localparam logic [1:0]      PG_1M         = 2'h3;
  localparam logic [18:0]     MASK_1K       = 19'h7ffff;
  localparam logic [18:0]     MASK_4K       = 19'h7fffc;
  localparam logic [18:0]     MASK_64K      = 19'h7ffc0;
  localparam logic [18:0]     MASK_1M       = 19'h7fc00;

  typedef enum logic [1:0] {OP_STORE, OP_PREFETCH, OP_LOAD} cpu_op_t;
  typedef enum logic [2:0] {EXC_NONE, EXC_TLB_MISS_RD, EXC_TLB_MISS_WR, EXC_PROT_RD,
                            EXC_PROT_WR, EXC_INIT_WRITE, EXC_ADDR_ERR} exc_t;

  typedef struct packed {
    logic        valid;
    cpu_op_t     op;
    logic [31:0] addr;
    logic        quad;
    logic [63:0] wdata;
    logic        user;
  } cpu_req_t;

  typedef struct packed {
    logic        hit;
    logic [18:0] ppn;
    logic [1:0]  size;
    logic [1:0]  prot;
    logic        dirty;
  } tlb_info_t;

  typedef struct packed {
    logic        done;
    exc_t        exc;
    logic [31:0] rdata;
  } cpu_resp_t;

  typedef struct packed {
    logic         valid;
    logic [28:0]  addr;
    logic [255:0] data;
  } mem_req_t;
endpackage

// ---- logic/sq_access_check.sv ----
// Exception decision for queue writes and transfers.
`timescale 1ns/1ps
module sq_access_check (
  input  wire logic              translate_en, // Translation enabled.
  input  wire logic              priv_only,    // Queue access limited to privileged mode.
  input  wire logic              user_mode,    // Access comes from user mode.
  input  wire logic              is_write,     // Store (write check) rather than transfer (read check).
  input  wire logic              in_area,      // Address lies in the queue window.
  input  wire sq_pkg::tlb_info_t tlb,          // Translation result for the address.
  output sq_pkg::exc_t           exc           // Resulting exception, none when clear.
);
  logic prot_fail;

  always_comb
  begin
    prot_fail = (user_mode && !tlb.prot[sq_pkg::PROT_USER_BIT]) ||
                (is_write && !tlb.prot[sq_pkg::PROT_WRITE_BIT]);
    exc = sq_pkg::EXC_NONE;
    if (!in_area)
      exc = sq_pkg::EXC_ADDR_ERR;
    else if (!translate_en)
    begin
      if (priv_only && user_mode)
        exc = sq_pkg::EXC_ADDR_ERR;
    end
    else if (!tlb.hit)
      exc = is_write ? sq_pkg::EXC_TLB_MISS_WR : sq_pkg::EXC_TLB_MISS_RD;
    else if (priv_only && user_mode)
      exc = sq_pkg::EXC_ADDR_ERR;
    else if (prot_fail)
      exc = is_write ? sq_pkg::EXC_PROT_WR : sq_pkg::EXC_PROT_RD;
    else if (is_write && !tlb.dirty)
      exc = sq_pkg::EXC_INIT_WRITE;
  end
endmodule

// ---- logic/sq_dest_addr.sv ----
// Destination physical address of a queue burst.
`timescale 1ns/1ps
module sq_dest_addr (
  input  wire logic              translate_en, // Translation enabled.
  input  wire logic              queue_sel,    // Queue picked by the prefetch address.
  input  wire logic [31:0]       vaddr,        // Prefetch address.
  input  wire logic [2:0]        area_a,       // High address bits for the first queue.
  input  wire logic [2:0]        area_b,       // High address bits for the second queue.
  input  wire sq_pkg::tlb_info_t tlb,          // Translation result.
  output logic      [28:0]       paddr         // Burst start address, 32-byte aligned.
);
  logic [18:0] mask;
  logic [18:0] merged;

  always_comb
  begin
    unique case (tlb.size)
      sq_pkg::PG_1K:  mask = sq_pkg::MASK_1K;
      sq_pkg::PG_4K:  mask = sq_pkg::MASK_4K;
      sq_pkg::PG_64K: mask = sq_pkg::MASK_64K;
      sq_pkg::PG_1M:  mask = sq_pkg::MASK_1M;
    endcase
    // Frame bits come from the page entry, offset bits from the address.
    merged = (tlb.ppn & mask) | (vaddr[28:10] & ~mask);
    if (translate_en)
      paddr = {merged, vaddr[9:5], {sq_pkg::BURST_BITS{1'b0}}};
    else
      paddr = {(queue_sel ? area_b : area_a), vaddr[25:5], {sq_pkg::BURST_BITS{1'b0}}};
  end
endmodule

// ---- logic/store_queue_write_buffer.sv ----
// Store queue write buffer: two queues, burst drain, register slave and read-back.
`timescale 1ns/1ps
module store_queue_write_buffer (
  input  wire logic              hclk,      // Clock, 250 MHz.
  input  wire logic              hresetn,   // Asynchronous reset, active low.
  input  wire logic              hsel,      // Slave select.
  input  wire logic [31:0]       haddr,     // Bus address.
  input  wire logic [1:0]        htrans,    // Transfer type.
  input  wire logic              hwrite,    // Write when high.
  input  wire logic [2:0]        hsize,     // Transfer size.
  input  wire logic [31:0]       hwdata,    // Write data.
  input  wire logic              hready,    // Bus ready.
  output logic                   hreadyout, // Slave ready.
  output logic                   hresp,     // Response, always OKAY.
  output logic      [31:0]       hrdata,    // Read data.
  input  wire sq_pkg::cpu_req_t  cpu_req,   // Pipeline request, held until done.
  input  wire sq_pkg::tlb_info_t cpu_tlb,   // Translation of the request address.
  output sq_pkg::cpu_resp_t      cpu_resp,  // Completion pulse with exception and data.
  output sq_pkg::mem_req_t       mem_req,   // Burst write request to memory.
  input  wire logic              mem_ready  // Memory accepts the burst.
);
  localparam int ENTRIES = sq_pkg::QUEUES * sq_pkg::SLOTS;
  localparam int IDX_W   = sq_pkg::IDX_BITS;

  logic                at_r;
  logic                privonly_r;
  logic [2:0]          qac_a_r;
  logic [2:0]          qac_b_r;
  logic                at_nxt;
  logic                privonly_nxt;
  logic [2:0]          qac_a_nxt;
  logic [2:0]          qac_b_nxt;
  logic                wr_pend_r;
  logic [7:0]          wr_addr_r;
  logic [31:0]         hrdata_r;
  logic [31:0]         rd_val;
  logic                hreadyout_r;
  logic                hresp_r;
  logic                addr_phase;
  logic [31:0]         queue_mem_r [ENTRIES];
  sq_pkg::cpu_resp_t   cpu_resp_r;
  sq_pkg::mem_req_t    mem_req_r;
  sq_pkg::exc_t        last_exc_r;
  logic                drain_q_r;
  logic                q_sel;
  logic [2:0]          slot;
  logic                in_sq;
  logic                in_rb;
  logic                is_store;
  logic                is_prefetch;
  logic                is_load;
  logic                hold;
  logic                take;
  logic                ok;
  sq_pkg::exc_t        chk_exc;
  sq_pkg::exc_t        req_exc;
  logic [28:0]         dest_addr;
  logic [IDX_W-1:0]    idx_lo;
  logic [IDX_W-1:0]    idx_hi;
  logic                wr_lo;
  logic                wr_hi;
  logic [255:0]        drain_data;

  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign hrdata    = hrdata_r;
  assign cpu_resp  = cpu_resp_r;
  assign mem_req   = mem_req_r;

  // Register slave; zero wait states, so reads forward a write still in its data phase.
  assign addr_phase = hsel && hready && htrans[1];

  always_comb
  begin
    at_nxt       = at_r;
    privonly_nxt = privonly_r;
    qac_a_nxt    = qac_a_r;
    qac_b_nxt    = qac_b_r;
    if (wr_pend_r && wr_addr_r == sq_pkg::OFF_MMU_CTRL)
    begin
      at_nxt       = hwdata[sq_pkg::AT_BIT];
      privonly_nxt = hwdata[sq_pkg::PRIVONLY_BIT];
    end
    if (wr_pend_r && wr_addr_r == sq_pkg::OFF_QAC_A)
      qac_a_nxt = hwdata[sq_pkg::QAC_MSB:sq_pkg::QAC_LSB];
    if (wr_pend_r && wr_addr_r == sq_pkg::OFF_QAC_B)
      qac_b_nxt = hwdata[sq_pkg::QAC_MSB:sq_pkg::QAC_LSB];
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      sq_pkg::OFF_MMU_CTRL:
      begin
        rd_val[sq_pkg::AT_BIT]       = at_nxt;
        rd_val[sq_pkg::PRIVONLY_BIT] = privonly_nxt;
      end
      sq_pkg::OFF_QAC_A: rd_val[sq_pkg::QAC_MSB:sq_pkg::QAC_LSB] = qac_a_nxt;
      sq_pkg::OFF_QAC_B: rd_val[sq_pkg::QAC_MSB:sq_pkg::QAC_LSB] = qac_b_nxt;
      sq_pkg::OFF_STATUS:
      begin
        rd_val[sq_pkg::ST_BUSY_BIT]                    = mem_req_r.valid;
        rd_val[sq_pkg::ST_QUEUE_BIT]                   = drain_q_r;
        rd_val[sq_pkg::ST_EXC_MSB:sq_pkg::ST_EXC_LSB]  = last_exc_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        wr_pend_r <= addr_phase && hwrite;
        wr_addr_r <= haddr[7:0];
      end
      if (addr_phase && !hwrite)
        hrdata_r <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      at_r       <= sq_pkg::RST_AT;
      privonly_r <= sq_pkg::RST_PRIVONLY;
      qac_a_r    <= sq_pkg::RST_QAC;
      qac_b_r    <= sq_pkg::RST_QAC;
    end
    else
    begin
      at_r       <= at_nxt;
      privonly_r <= privonly_nxt;
      qac_a_r    <= qac_a_nxt;
      qac_b_r    <= qac_b_nxt;
    end
  end

  // Request decode.
  always_comb
  begin
    q_sel    = cpu_req.addr[sq_pkg::QSEL_BIT];
    slot     = cpu_req.addr[sq_pkg::SLOT_MSB:sq_pkg::SLOT_LSB];
    in_sq    = cpu_req.addr[31:sq_pkg::SQ_TAG_LSB] == sq_pkg::SQ_AREA_TAG;
    in_rb    = cpu_req.addr[31:sq_pkg::RB_TAG_LSB] == sq_pkg::RB_AREA_TAG;
    is_store = cpu_req.op == sq_pkg::OP_STORE;
    is_prefetch = cpu_req.op == sq_pkg::OP_PREFETCH;
    is_load  = cpu_req.op == sq_pkg::OP_LOAD;
    if (is_load)
      req_exc = (in_rb && !cpu_req.user) ? sq_pkg::EXC_NONE : sq_pkg::EXC_ADDR_ERR;
    else if (is_store || is_prefetch)
      req_exc = chk_exc;
    else
      req_exc = sq_pkg::EXC_ADDR_ERR;
    hold = (is_store && mem_req_r.valid && drain_q_r == q_sel) || (is_prefetch && mem_req_r.valid);
    take = cpu_req.valid && !cpu_resp_r.done && !hold;
    ok   = take && req_exc == sq_pkg::EXC_NONE;
  end

  sq_access_check u_check (
    .translate_en (at_r),
    .priv_only    (privonly_r),
    .user_mode    (cpu_req.user),
    .is_write     (is_store),
    .in_area      (in_sq),
    .tlb          (cpu_tlb),
    .exc          (chk_exc)
  );

  sq_dest_addr u_dest (
    .translate_en (at_r),
    .queue_sel    (q_sel),
    .vaddr        (cpu_req.addr),
    .area_a       (qac_a_r),
    .area_b       (qac_b_r),
    .tlb          (cpu_tlb),
    .paddr        (dest_addr)
  );

  // Queue storage; a quadword store fills an even slot and the one above it.
  always_comb
  begin
    idx_lo = cpu_req.quad ? {q_sel, slot[2:1], 1'b0} : {q_sel, slot};
    idx_hi = {q_sel, slot[2:1], 1'b1};
    wr_lo  = ok && is_store;
    wr_hi  = ok && is_store && cpu_req.quad;
  end

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          queue_mem_r[g] <= 32'h0000_0000;
        else if (wr_lo && idx_lo == IDX_W'(g))
          queue_mem_r[g] <= cpu_req.wdata[31:0];
        else if (wr_hi && idx_hi == IDX_W'(g))
          queue_mem_r[g] <= cpu_req.wdata[63:32];
      end
    end
  endgenerate

  always_comb
  begin
    drain_data = 256'h0;
    for (int i = 0; i < sq_pkg::SLOTS; i++)
      drain_data[i*sq_pkg::LW_BITS +: sq_pkg::LW_BITS] = queue_mem_r[{q_sel, 3'(i)}];
  end

  // Completion towards the pipeline.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_resp_r <= '0;
      last_exc_r <= sq_pkg::EXC_NONE;
    end
    else
    begin
      cpu_resp_r.done <= take;
      if (take)
      begin
        cpu_resp_r.exc   <= req_exc;
        cpu_resp_r.rdata <= (ok && is_load) ? queue_mem_r[{q_sel, slot}] : 32'h0000_0000;
        last_exc_r       <= req_exc;
      end
    end
  end

  // Burst drain; the request stands until memory accepts it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_req_r <= '0;
      drain_q_r <= 1'b0;
    end
    else if (ok && is_prefetch)
    begin
      mem_req_r.valid <= 1'b1;
      mem_req_r.addr  <= dest_addr;
      mem_req_r.data  <= drain_data;
      drain_q_r       <= q_sel;
    end
    else if (mem_req_r.valid && mem_ready)
      mem_req_r.valid <= 1'b0;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_busy_store_held: assert property (
    cpu_req.valid && is_store && mem_req_r.valid && drain_q_r == q_sel && !mem_ready |=> !cpu_resp_r.done)
    else $error("store to draining queue was not held");
  a_other_queue_free: assert property (
    cpu_req.valid && is_store && !cpu_resp_r.done && mem_req_r.valid && drain_q_r != q_sel |=> cpu_resp_r.done)
    else $error("store to idle queue stalled");
  a_burst_aligned: assert property (mem_req_r.valid |-> mem_req_r.addr[4:0] == 5'h00)
    else $error("burst address not 32-byte aligned");
  a_plain_low_bits: assert property (
    ok && is_prefetch && !at_r |=> mem_req_r.addr[25:5] == $past(cpu_req.addr[25:5]))
    else $error("untranslated destination bits wrong");
  a_area_high_bits: assert property (
    ok && is_prefetch && !at_r |=> mem_req_r.addr[28:26] == ($past(q_sel) ? $past(qac_b_r) : $past(qac_a_r)))
    else $error("destination high bits not from area control");
  a_xlat_offset: assert property (
    ok && is_prefetch && at_r |=> mem_req_r.addr[9:5] == $past(cpu_req.addr[9:5]) && mem_req_r.valid)
    else $error("translated burst offset bits wrong");
  a_fault_keeps_data: assert property (
    take && is_store && req_exc != sq_pkg::EXC_NONE |=> queue_mem_r[$past(idx_lo)] == $past(queue_mem_r[idx_lo]))
    else $error("faulting store changed queue");
  a_fault_no_burst: assert property (
    take && is_prefetch && req_exc != sq_pkg::EXC_NONE |=> !$rose(mem_req_r.valid))
    else $error("faulting prefetch started a burst");
  a_user_addr_err: assert property (
    take && cpu_req.user && privonly_r && in_sq && (is_store || is_prefetch) && (!at_r || cpu_tlb.hit)
    |=> cpu_resp_r.exc == sq_pkg::EXC_ADDR_ERR)
    else $error("user access not refused");
  a_burst_stands: assert property (
    mem_req_r.valid && !mem_ready |=> mem_req_r.valid && $stable(mem_req_r.addr) && $stable(mem_req_r.data))
    else $error("burst withdrawn before accept");
  a_readback_data: assert property (
    ok && is_load |=> cpu_resp_r.rdata == $past(queue_mem_r[{q_sel, slot}]) && cpu_resp_r.done)
    else $error("read-back data wrong");
endmodule

// ---- tb/sq_mem_model.sv ----
// Behavioural model of the external memory port that accepts queue bursts.
`timescale 1ns/1ps
module sq_mem_model (
  input  wire logic             hclk,      // Clock.
  input  wire logic             hresetn,   // Asynchronous reset, active low.
  input  wire sq_pkg::mem_req_t mem_req,   // Burst request from the block.
  input  wire logic             stall,     // Holds off acceptance while high.
  output logic                  mem_ready, // Accepts the burst.
  output logic      [28:0]      last_addr, // Address of the last accepted burst.
  output logic      [255:0]     last_data, // Data of the last accepted burst.
  output int                    bursts     // Number of accepted bursts.
);
  // Ready follows a pending request by one cycle, so a stall makes the memory slow.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mem_ready <= 1'b0;
    else
      mem_ready <= mem_req.valid & ~stall & ~mem_ready;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_addr <= '0;
      last_data <= '0;
      bursts    <= 0;
    end
    else if (mem_req.valid && mem_ready)
    begin
      last_addr <= mem_req.addr;
      last_data <= mem_req.data;
      bursts    <= bursts + 1;
    end
  end
endmodule

// ---- tb/store_queue_write_buffer_tb.sv ----
// Self-checking testbench of the store queue write buffer.
`timescale 1ns/1ps
module store_queue_write_buffer_tb;
  localparam sq_pkg::tlb_info_t TMISS = '0;
  localparam sq_pkg::tlb_info_t THIT  = '{1'b1, 19'h12345, sq_pkg::PG_1K, 2'b11, 1'b1};
  localparam sq_pkg::tlb_info_t TPROT = '{1'b1, 19'h12345, sq_pkg::PG_1K, 2'b00, 1'b1};
  localparam sq_pkg::tlb_info_t TCLEAN = '{1'b1, 19'h12345, sq_pkg::PG_1K, 2'b11, 1'b0};
  localparam sq_pkg::tlb_info_t TBIG  = '{1'b1, 19'h12345, sq_pkg::PG_1M, 2'b11, 1'b1};
  logic                hclk      = 1'b0;
  logic                hresetn   = 1'b0;
  logic                hsel      = 1'b0;
  logic [31:0]         haddr     = '0;
  logic [1:0]          htrans    = '0;
  logic                hwrite    = 1'b0;
  logic [2:0]          hsize     = '0;
  logic [31:0]         hwdata    = '0;
  logic                hro;
  logic                hresp;
  logic [31:0]         hrdata;
  sq_pkg::cpu_req_t    cpu_req   = '0;
  sq_pkg::tlb_info_t   cpu_tlb   = '0;
  sq_pkg::cpu_resp_t   cpu_resp;
  sq_pkg::mem_req_t    mem_req;
  logic                mem_ready;
  logic                stall     = 1'b0;
  logic [28:0]         last_addr;
  logic [255:0]        last_data;
  int                  bursts;
  int                  err_total = 0;
  int                  checks    = 0;
  int                  cyc       = 0;
  int                  n_v;
  logic [31:0]         rd_v;
  logic [31:0]         r;
  logic [31:0]         pa;
  logic [255:0]        exp_d;
  logic [31:0]         ra[5]     = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10};
  logic [31:0]         rx[5]     = '{32'h3, 32'h1c, 32'h1c, 32'h0, 32'h0};

  always #2 hclk = ~hclk;

  store_queue_write_buffer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hro), .hreadyout(hro), .hresp(hresp),
    .hrdata(hrdata), .cpu_req(cpu_req), .cpu_tlb(cpu_tlb), .cpu_resp(cpu_resp), .mem_req(mem_req),
    .mem_ready(mem_ready));

  sq_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .stall(stall), .mem_ready(mem_ready),
    .last_addr(last_addr), .last_data(last_data), .bursts(bursts));

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One single-word transfer; read data is taken at the end of the data phase.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rv);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hro !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hro !== 1'b1);
    rv = hrdata;
    check(hresp, 1'b0);
  endtask

  // Pipeline request held until the completion pulse; n_v counts cycles to it.
  task automatic cpu_do(input sq_pkg::cpu_op_t op, input logic [31:0] a, input logic q, input logic [63:0] d,
                        input logic u, input sq_pkg::tlb_info_t t, input sq_pkg::exc_t ee);
    int n;
    @(posedge hclk);
    cpu_req <= '{1'b1, op, a, q, d, u};
    cpu_tlb <= t;
    n = 0;
    do begin @(negedge hclk); n++; end while (cpu_resp.done !== 1'b1 && n < 300);
    n_v  = n;
    rd_v = cpu_resp.rdata;
    check(n < 300, 1'b1);
    check(cpu_resp.exc, ee);
    @(posedge hclk);
    cpu_req <= '0;
  endtask

  task automatic rb(input logic q, input logic [2:0] s, input logic [31:0] exp);
    cpu_do(sq_pkg::OP_LOAD, {26'h3fc0040, q, s, 2'b00}, 1'b0, '0, 1'b0, TMISS, sq_pkg::EXC_NONE);
    check(rd_v, exp);
  endtask

  task automatic wait_burst(input int k);
    int c;
    c = 0;
    while (bursts != k && c < 100)
    begin
      @(posedge hclk);
      c++;
    end
    check(bursts, k);
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b1, ra[i], 32'hffff_ffff, r);
      ahb(1'b0, ra[i], 32'h0, r);
      check(r, rx[i]);
    end
    ahb(1'b1, 32'h0, 32'h0, r);
    ahb(1'b1, 32'h4, 32'h14, r);
    ahb(1'b1, 32'h8, 32'h0c, r);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
      cpu_do(sq_pkg::OP_STORE, 32'he000_0000 + 32'(4 * i), 1'b0, {32'h0, 32'h1000_0000 + 32'(i)}, 1'b1, TMISS,
             sq_pkg::EXC_NONE);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0018, 1'b1, {32'h1000_0007, 32'h1000_0006}, 1'b1, TMISS,
           sq_pkg::EXC_NONE);
    for (int i = 0; i < 8; i++)
      exp_d[32 * i +: 32] = 32'h1000_0000 + 32'(i);
    pa = 32'he123_4540;
    cpu_do(sq_pkg::OP_PREFETCH, pa, 1'b0, '0, 1'b1, TMISS, sq_pkg::EXC_NONE);
    wait_burst(1);
    check(last_addr, {3'h5, pa[25:5], 5'h00});
    check(last_data, exp_d);
    $display("test fill and drain done");
    stall <= 1'b1;
    cpu_do(sq_pkg::OP_PREFETCH, 32'he000_0000, 1'b0, '0, 1'b0, TMISS, sq_pkg::EXC_NONE);
    ahb(1'b0, 32'hc, 32'h0, r);
    check(r, 32'h1);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0020, 1'b0, {32'h0, 32'hb0b0_0000}, 1'b0, TMISS, sq_pkg::EXC_NONE);
    check(n_v, 2);
    fork
      cpu_do(sq_pkg::OP_STORE, 32'he000_0000, 1'b0, {32'h0, 32'haaaa_5555}, 1'b0, TMISS, sq_pkg::EXC_NONE);
      begin
        repeat (20) @(posedge hclk);
        stall <= 1'b0;
      end
    join
    check(n_v > 20, 1'b1);
    check(bursts, 2);
    check(last_data[31:0], 32'h1000_0000);
    rb(1'b0, 3'h0, 32'haaaa_5555);
    rb(1'b1, 3'h0, 32'hb0b0_0000);
    cpu_do(sq_pkg::OP_LOAD, 32'hff00_1000, 1'b0, '0, 1'b1, TMISS, sq_pkg::EXC_ADDR_ERR);
    check(rd_v, 32'h0);
    $display("test stall done");
    ahb(1'b1, 32'h0, 32'h2, r);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0004, 1'b0, {32'h0, 32'hdead}, 1'b1, TMISS, sq_pkg::EXC_ADDR_ERR);
    rb(1'b0, 3'h1, 32'h1000_0001);
    cpu_do(sq_pkg::OP_PREFETCH, 32'he000_0000, 1'b0, '0, 1'b1, TMISS, sq_pkg::EXC_ADDR_ERR);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0004, 1'b0, {32'h0, 32'h1111_0001}, 1'b0, TMISS, sq_pkg::EXC_NONE);
    check(bursts, 2);
    $display("test privilege done");
    ahb(1'b1, 32'h0, 32'h1, r);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0004, 1'b0, {32'h0, 32'hbad}, 1'b0, TMISS, sq_pkg::EXC_TLB_MISS_WR);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0004, 1'b0, {32'h0, 32'hbad}, 1'b0, TPROT, sq_pkg::EXC_PROT_WR);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0004, 1'b0, {32'h0, 32'hbad}, 1'b0, TCLEAN, sq_pkg::EXC_INIT_WRITE);
    rb(1'b0, 3'h1, 32'h1111_0001);
    cpu_do(sq_pkg::OP_PREFETCH, 32'he000_0000, 1'b0, '0, 1'b0, TMISS, sq_pkg::EXC_TLB_MISS_RD);
    cpu_do(sq_pkg::OP_PREFETCH, 32'he000_0000, 1'b0, '0, 1'b1, TPROT, sq_pkg::EXC_PROT_RD);
    check(bursts, 2);
    ahb(1'b1, 32'h0, 32'h3, r);
    cpu_do(sq_pkg::OP_STORE, 32'he000_0004, 1'b0, {32'h0, 32'hbad}, 1'b1, THIT, sq_pkg::EXC_ADDR_ERR);
    ahb(1'b1, 32'h0, 32'h1, r);
    cpu_do(sq_pkg::OP_PREFETCH, 32'he000_03e0, 1'b0, '0, 1'b0, THIT, sq_pkg::EXC_NONE);
    wait_burst(3);
    check(last_addr, {19'h12345, 5'h1f, 5'h00});
    check(last_data[31:0], 32'hb0b0_0000);
    cpu_do(sq_pkg::OP_PREFETCH, 32'he00f_fc20, 1'b0, '0, 1'b0, TBIG, sq_pkg::EXC_NONE);
    wait_burst(4);
    check(last_addr, {19'h123ff, 5'h01, 5'h00});
    $display("test translation done");
    print_verdict();
  end
endmodule
